// ---- rtl/aps_regs.sv ----
// Arbitrary pulse segment five to seven registers and amplitude selector
`default_nettype none

// Operation
// - Segment amplitudes shape the output only while arbitrary mode is selected.
// - One pulse spans one master clock period, split into eight segments.
// - Amplitude is seven bits in 6..0; bit 7 reserved, writable, resets zero.
// - Amplitude is signed magnitude: bit 6 sign, bits 5..0 magnitude.
// - Address 01100 holds segment five amplitude, read/write, resets zero.
// - Address 01101 holds segment six amplitude, read/write, resets zero.
// - Address 01110 holds segment seven amplitude, read/write, resets zero.
// - Address 01111 supplies segment eight amplitude in the same format.

module aps_regs
	import aps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	input wire logic arb_mode,
	input wire logic period_start,
	input wire logic seg_strobe,
	input wire logic [6:0] seg_one_amp,
	input wire logic [6:0] seg_two_amp,
	input wire logic [6:0] seg_three_amp,
	input wire logic [6:0] seg_four_amp,
	input wire logic [6:0] seg_eight_amp,
	output logic [6:0] seg_five_amp,
	output logic [6:0] seg_six_amp,
	output logic [6:0] seg_seven_amp,
	output logic shape_active,
	output logic shape_sign,
	output logic [5:0] shape_mag,
	output logic [2:0] shape_segment
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic amp_sign(input logic [6:0] amp);
		amp_sign = amp[SIGN_BIT];
	endfunction

	function automatic logic [5:0] amp_mag(input logic [6:0] amp);
		amp_mag = amp[MAG_MSB:MAG_LSB];
	endfunction

	function automatic logic own_addr(input logic [4:0] a);
		own_addr = (a == SEG_FIVE_ADDR) || (a == SEG_SIX_ADDR) ||
			(a == SEG_SEVEN_ADDR);
	endfunction

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	logic [7:0] five_reg;
	logic [7:0] five_next;
	logic [7:0] six_reg;
	logic [7:0] six_next;
	logic [7:0] seven_reg;
	logic [7:0] seven_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic ack_reg;
	logic ack_next;

	// Whole byte is stored; reserved bit 7 reads back what was written
	always_comb begin
		five_next = five_reg;
		six_next = six_reg;
		seven_next = seven_reg;
		if (reg_wr) begin
			case (reg_addr)
				SEG_FIVE_ADDR: five_next = reg_wdata;
				SEG_SIX_ADDR: six_next = reg_wdata;
				SEG_SEVEN_ADDR: seven_next = reg_wdata;
				default: five_next = five_reg;
			endcase
		end
	end

	// Reads answer one cycle later; other addresses belong elsewhere
	always_comb begin
		rdata_next = UNMAPPED_READ;
		ack_next = (reg_wr || reg_rd) && own_addr(reg_addr);
		if (reg_rd) begin
			case (reg_addr)
				SEG_FIVE_ADDR: rdata_next = five_reg;
				SEG_SIX_ADDR: rdata_next = six_reg;
				SEG_SEVEN_ADDR: rdata_next = seven_reg;
				default: rdata_next = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			five_reg <= SEG_REG_RESET;
			six_reg <= SEG_REG_RESET;
			seven_reg <= SEG_REG_RESET;
			rdata_reg <= UNMAPPED_READ;
			ack_reg <= 1'b0;
		end else begin
			five_reg <= five_next;
			six_reg <= six_next;
			seven_reg <= seven_next;
			rdata_reg <= rdata_next;
			ack_reg <= ack_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_ack = ack_reg;
	assign seg_five_amp = five_reg[AMP_W-1:0];
	assign seg_six_amp = six_reg[AMP_W-1:0];
	assign seg_seven_amp = seven_reg[AMP_W-1:0];

	// ------------------------------------------------------------
	// Segment walk
	// ------------------------------------------------------------
	logic [2:0] seg_idx;

	aps_seg_seq u_seq (
		.clk(clk),
		.rst(rst),
		.period_start(period_start),
		.seg_strobe(seg_strobe),
		.seg_idx(seg_idx)
	);

	// ------------------------------------------------------------
	// Amplitude selection
	// ------------------------------------------------------------
	logic [6:0] cur_amp;
	logic act_reg;
	logic act_next;
	logic sign_reg;
	logic sign_next;
	logic [5:0] mag_reg;
	logic [5:0] mag_next;
	logic [2:0] segout_reg;
	logic [2:0] segout_next;

	always_comb begin
		case (seg_idx)
			IDX_ONE: cur_amp = seg_one_amp;
			IDX_TWO: cur_amp = seg_two_amp;
			IDX_THREE: cur_amp = seg_three_amp;
			IDX_FOUR: cur_amp = seg_four_amp;
			IDX_FIVE: cur_amp = five_reg[AMP_W-1:0];
			IDX_SIX: cur_amp = six_reg[AMP_W-1:0];
			IDX_SEVEN: cur_amp = seven_reg[AMP_W-1:0];
			IDX_EIGHT: cur_amp = seg_eight_amp;
			default: cur_amp = seg_one_amp;
		endcase
	end

	// Outside arbitrary mode the shaper sees zero, not stale values
	always_comb begin
		act_next = arb_mode;
		segout_next = seg_idx;
		if (arb_mode) begin
			sign_next = amp_sign(cur_amp);
			mag_next = amp_mag(cur_amp);
		end else begin
			sign_next = 1'b0;
			mag_next = MAG_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_reg <= 1'b0;
			sign_reg <= 1'b0;
			mag_reg <= MAG_IDLE;
			segout_reg <= IDX_ONE;
		end else begin
			act_reg <= act_next;
			sign_reg <= sign_next;
			mag_reg <= mag_next;
			segout_reg <= segout_next;
		end
	end

	assign shape_active = act_reg;
	assign shape_sign = sign_reg;
	assign shape_mag = mag_reg;
	assign shape_segment = segout_reg;

endmodule

`default_nettype wire

// ---- inc/aps_pkg.sv ----
// Constants and types for the arbitrary pulse segment register bank
`default_nettype none

package aps_pkg;

	// ------------------------------------------------------------
	// Register addresses on the host register port
	// ------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] SEG_FIVE_ADDR = 5'h0C;
	localparam logic [4:0] SEG_SIX_ADDR = 5'h0D;
	localparam logic [4:0] SEG_SEVEN_ADDR = 5'h0E;
	localparam logic [4:0] SEG_EIGHT_ADDR = 5'h0F;

	// ------------------------------------------------------------
	// Field layout and reset values
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int AMP_W = 7;
	localparam int MAG_W = 6;
	localparam int RSVD_BIT = 7;
	localparam int SIGN_BIT = 6;
	localparam int MAG_MSB = 5;
	localparam int MAG_LSB = 0;
	localparam logic [7:0] SEG_REG_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	localparam logic [5:0] MAG_IDLE = 6'h00;

	// ------------------------------------------------------------
	// Segment timing: eight segments per master clock period
	// ------------------------------------------------------------
	localparam int SEG_COUNT = 8;
	localparam int SEG_IDX_W = 3;

	// Gray code along the segment walk, one to eight
	typedef enum logic [2:0] {
		SEG_ONE = 3'h0,
		SEG_TWO = 3'h1,
		SEG_THREE = 3'h3,
		SEG_FOUR = 3'h2,
		SEG_FIVE = 3'h6,
		SEG_SIX = 3'h7,
		SEG_SEVEN = 3'h5,
		SEG_EIGHT = 3'h4
	} aps_seg_t;

	localparam logic [2:0] IDX_ONE = 3'h0;
	localparam logic [2:0] IDX_TWO = 3'h1;
	localparam logic [2:0] IDX_THREE = 3'h2;
	localparam logic [2:0] IDX_FOUR = 3'h3;
	localparam logic [2:0] IDX_FIVE = 3'h4;
	localparam logic [2:0] IDX_SIX = 3'h5;
	localparam logic [2:0] IDX_SEVEN = 3'h6;
	localparam logic [2:0] IDX_EIGHT = 3'h7;

endpackage

`default_nettype wire

// ---- rtl/aps_seg_seq.sv ----
// Segment sequencer walking the eight pulse segments of one period
`default_nettype none

module aps_seg_seq
	import aps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic period_start,
	input wire logic seg_strobe,
	output logic [2:0] seg_idx
);

	// ------------------------------------------------------------
	// Segment state
	// ------------------------------------------------------------
	aps_seg_t seg_reg;
	aps_seg_t seg_next;
	logic [2:0] idx_reg;
	logic [2:0] idx_next;

	function automatic logic [2:0] seg_to_idx(input aps_seg_t s);
		case (s)
			SEG_ONE: seg_to_idx = IDX_ONE;
			SEG_TWO: seg_to_idx = IDX_TWO;
			SEG_THREE: seg_to_idx = IDX_THREE;
			SEG_FOUR: seg_to_idx = IDX_FOUR;
			SEG_FIVE: seg_to_idx = IDX_FIVE;
			SEG_SIX: seg_to_idx = IDX_SIX;
			SEG_SEVEN: seg_to_idx = IDX_SEVEN;
			SEG_EIGHT: seg_to_idx = IDX_EIGHT;
			default: seg_to_idx = IDX_ONE;
		endcase
	endfunction

	// Period start wins so a lost strobe cannot skew the next pulse
	always_comb begin
		seg_next = seg_reg;
		if (period_start) begin
			seg_next = SEG_ONE;
		end else if (seg_strobe) begin
			case (seg_reg)
				SEG_ONE: seg_next = SEG_TWO;
				SEG_TWO: seg_next = SEG_THREE;
				SEG_THREE: seg_next = SEG_FOUR;
				SEG_FOUR: seg_next = SEG_FIVE;
				SEG_FIVE: seg_next = SEG_SIX;
				SEG_SIX: seg_next = SEG_SEVEN;
				SEG_SEVEN: seg_next = SEG_EIGHT;
				SEG_EIGHT: seg_next = SEG_ONE;
				default: seg_next = SEG_ONE;
			endcase
		end
		idx_next = seg_to_idx(seg_next);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seg_reg <= SEG_ONE;
			idx_reg <= IDX_ONE;
		end else begin
			seg_reg <= seg_next;
			idx_reg <= idx_next;
		end
	end

	assign seg_idx = idx_reg;

endmodule

`default_nettype wire

// ---- verification/aps_regs_asserts.sv ----
// Port checker for the pulse segment register bank
`default_nettype none

module aps_regs_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic arb_mode,
	input wire logic period_start,
	input wire logic seg_strobe,
	input wire logic [6:0] seg_five_amp,
	input wire logic [6:0] seg_seven_amp,
	input wire logic shape_active,
	input wire logic shape_sign,
	input wire logic [5:0] shape_mag,
	input wire logic [2:0] shape_segment
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	a_ack_mapped: assert property (
		(reg_wr || reg_rd) && reg_addr inside {[5'h0C:5'h0E]} |=> reg_ack)
		else $error("ack missing for mapped access");
	a_ack_unmapped: assert property (
		(reg_wr || reg_rd) && !(reg_addr inside {[5'h0C:5'h0E]})
		|=> !reg_ack)
		else $error("ack on unmapped access");
	a_wr_five: assert property (
		reg_wr && reg_addr == 5'h0C |=> seg_five_amp == $past(reg_wdata[6:0]))
		else $error("segment five write lost");
	a_wr_seven: assert property (
		reg_wr && reg_addr == 5'h0E |=> seg_seven_amp == $past(reg_wdata[6:0]))
		else $error("segment seven write lost");
	a_rd_five: assert property (
		reg_rd && !reg_wr && reg_addr == 5'h0C
		|=> reg_rdata[6:0] == $past(seg_five_amp))
		else $error("segment five read wrong");

	// ------------------------------------------------------------
	// Segment walk
	// ------------------------------------------------------------
	// Two quiet cycles first, so the index pipeline is settled
	a_seg_step: assert property (
		(!seg_strobe && !period_start) [*2] ##1 (seg_strobe && !period_start)
		|-> ##2 shape_segment == $past(shape_segment, 2) + 3'h1)
		else $error("segment did not advance by one");
	a_seg_start: assert property (period_start |-> ##2 shape_segment == 3'h0)
		else $error("period start did not restart at one");
	a_mode_off: assert property (
		!arb_mode ##1 !arb_mode |=> !shape_sign && shape_mag == 6'h00)
		else $error("shape driven outside arbitrary mode");
	a_seg_amp: assert property (
		shape_active && shape_segment == 3'h4 && $stable(seg_five_amp)
		|-> {shape_sign, shape_mag} == seg_five_amp)
		else $error("segment five amplitude not presented");
endmodule

bind aps_regs aps_regs_chk u_aps_regs_chk (
	.clk(clk),
	.rst(rst),
	.reg_addr(reg_addr),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata),
	.reg_ack(reg_ack),
	.arb_mode(arb_mode),
	.period_start(period_start),
	.seg_strobe(seg_strobe),
	.seg_five_amp(seg_five_amp),
	.seg_seven_amp(seg_seven_amp),
	.shape_active(shape_active),
	.shape_sign(shape_sign),
	.shape_mag(shape_mag),
	.shape_segment(shape_segment)
);

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the pulse segment register bank
`default_nettype none

module tb import aps_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic arb_mode = 1'b0, period_start = 1'b0, seg_strobe = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic reg_ack, shape_active, shape_sign;
	logic [6:0] seg_one_amp = 7'h01, seg_two_amp = 7'h42;
	logic [6:0] seg_three_amp = 7'h03, seg_four_amp = 7'h44;
	logic [6:0] seg_eight_amp = 7'h7F;
	logic [6:0] seg_five_amp, seg_six_amp, seg_seven_amp;
	logic [5:0] shape_mag;
	logic [2:0] shape_segment;
	logic [6:0] amp [8] = '{7'h01, 7'h42, 7'h03, 7'h44, 7'h05, 7'h46,
		7'h3F, 7'h7F};
	logic [7:0] wd [3] = '{8'h85, 8'h46, 8'hBF};
	int failures = 0, num_checks = 0, cyc = 0;

	aps_regs u_aps_regs (
		.clk(clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_ack(reg_ack),
		.arb_mode(arb_mode),
		.period_start(period_start),
		.seg_strobe(seg_strobe),
		.seg_one_amp(seg_one_amp),
		.seg_two_amp(seg_two_amp),
		.seg_three_amp(seg_three_amp),
		.seg_four_amp(seg_four_amp),
		.seg_eight_amp(seg_eight_amp),
		.seg_five_amp(seg_five_amp),
		.seg_six_amp(seg_six_amp),
		.seg_seven_amp(seg_seven_amp),
		.shape_active(shape_active),
		.shape_sign(shape_sign),
		.shape_mag(shape_mag),
		.shape_segment(shape_segment)
	);

	always #10 clk = ~clk;

	// Whole run needs under two hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			failures++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task stop_test();
		if (failures == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// One strobe cycle; ack and read data stand only the cycle after it
	task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask

	task step(input logic ps);
		@(posedge clk);
		// Strobe rides along with period start, which must win
		period_start <= ps;
		seg_strobe <= 1'b1;
		@(posedge clk);
		period_start <= 1'b0;
		seg_strobe <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset();
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, SEG_FIVE_ADDR + 5'(i), 8'h00);
			chk(reg_rdata, 8'h00);
			chk({7'h00, reg_ack}, 8'h01);
		end
	endtask

	task t_rw();
		for (int i = 0; i < 3; i++) begin
			acc(1'b1, SEG_FIVE_ADDR + 5'(i), wd[i]);
			chk({7'h00, reg_ack}, 8'h01);
		end
		chk({1'b0, seg_five_amp}, 8'h05);
		chk({1'b0, seg_six_amp}, 8'h46);
		chk({1'b0, seg_seven_amp}, 8'h3F);
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, SEG_FIVE_ADDR + 5'(i), 8'h00);
			chk(reg_rdata, wd[i]);
		end
	endtask

	// Segment eight lives outside this bank
	task t_unmapped();
		acc(1'b1, SEG_EIGHT_ADDR, 8'hFF);
		chk({7'h00, reg_ack}, 8'h00);
		acc(1'b0, SEG_EIGHT_ADDR, 8'h00);
		chk(reg_rdata, 8'h00);
		chk({1'b0, seg_seven_amp}, 8'h3F);
	endtask

	task t_walk(input logic m);
		@(posedge clk);
		arb_mode <= m;
		for (int i = 0; i < 9; i++) begin
			step(i == 0);
			chk({5'h00, shape_segment}, 8'(i % 8));
			chk({1'b0, shape_sign, shape_mag},
				m ? {1'b0, amp[i % 8]} : 8'h00);
			chk({7'h00, shape_active}, {7'h00, m});
		end
	endtask

	// Reset in mid-run must clear what was written
	task t_rerst();
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({1'b0, seg_five_amp}, 8'h00);
		chk({1'b0, seg_six_amp}, 8'h00);
		chk({1'b0, seg_seven_amp}, 8'h00);
		chk({5'h00, shape_segment}, 8'h00);
		t_reset();
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_rw();
		t_unmapped();
		t_walk(1'b1);
		t_walk(1'b0);
		t_rerst();
		stop_test();
	end
endmodule

`default_nettype wire
